// ---- design/calib_port_pkg.sv ----
// Package: register map, field positions, reset values and timing for the calibration and reset port
package calib_port_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_EE_PORT  = 8'h18;
  localparam logic [7:0] IDX_POT_PORT = 8'h19;
  localparam logic [7:0] IDX_RESET    = 8'h1B;
  localparam logic [7:0] IDX_POT_SEL  = 8'h20;
  localparam logic [7:0] IDX_POT_VAL  = 8'h21;
  localparam logic [7:0] IDX_STATUS   = 8'h22;

  // Serial port fields
  localparam int SER_DATA_BIT   = 7;
  localparam int SER_STROBE_BIT = 0;

  // Block_reset_control fields
  localparam int RST_ADC_BIT    = 0;
  localparam int RST_POT_BIT    = 1;
  localparam int RST_DIO_BIT    = 2;
  localparam int RST_DAC_BIT    = 3;
  localparam int RST_GLOBAL_BIT = 4;

  // Potentiometer frame: two address bits then eight setting bits
  localparam logic [3:0] POT_FRAME_BITS = 4'hA;
  localparam logic [7:0] POT_CLEAR_VALUE = 8'h80;
  localparam logic [1:0] POT_SEL_RESET   = 2'h0;

  // Status register fields
  localparam int ST_EE_BUSY_BIT   = 0;
  localparam int ST_POT_OPEN_BIT  = 1;
  localparam int ST_POT_FULL_BIT  = 2;
  localparam int ST_POT_CNT_LSB   = 4;

  // EEPROM busy window after the ending write
  localparam int CLK_MHZ         = 100;
  localparam int EE_BUSY_MS      = 20;
  localparam int EE_BUSY_CYCLES  = EE_BUSY_MS * 1000 * CLK_MHZ;

  // Potentiometer frame decoder states
  typedef enum logic [2:0] {
    POT_IDLE  = 3'b001,
    POT_SHIFT = 3'b010,
    POT_FULL  = 3'b100
  } pot_state_type;

endpackage

// ---- design/pot_bank_if.sv ----
// Interface: write and read path between the port logic and the potentiometer bank
`timescale 1ns/100ps
interface pot_bank_if;
  logic       wr_en;    // Commit one setting
  logic [1:0] wr_addr;  // Potentiometer select
  logic [7:0] wr_data;  // Setting to store
  logic       clr;      // Return all settings to clear value
  logic [1:0] rd_addr;  // Readback select
  logic [7:0] rd_data;  // Registered readback

  modport owner (output wr_en, output wr_addr, output wr_data, output clr, output rd_addr, input rd_data);
  modport bank  (input wr_en, input wr_addr, input wr_data, input clr, input rd_addr, output rd_data);
endinterface

// ---- design/pot_bank.sv ----
// Module: storage for the four calibration potentiometer settings
`timescale 1ns/100ps
module pot_bank #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 8
) (
  input wire logic  mclk,  // System clock
  input wire logic  rstn,  // Synchronous reset, active low
  pot_bank_if.bank  pb     // Write and readback path
);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [WIDTH-1:0] rd_data_reg;
  logic [WIDTH-1:0] rd_data_next;

  // Clear has priority; a commit never coincides with it from one bus write
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      mem_next[i] = mem_reg[i];
      if (pb.clr)
        mem_next[i] = calib_port_pkg::POT_CLEAR_VALUE;
      else if (pb.wr_en && (pb.wr_addr == i[1:0]))
        mem_next[i] = pb.wr_data;
    end
    rd_data_next = mem_reg[pb.rd_addr];
  end

  // Storage and registered readback
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= calib_port_pkg::POT_CLEAR_VALUE;
      rd_data_reg <= '0;
    end
    else
    begin
      mem_reg     <= mem_next;
      rd_data_reg <= rd_data_next;
    end
  end

  assign pb.rd_data = rd_data_reg;

  // A clear shows on readback of any slot two edges later
  AST_BANK_CLEAR: assert property (@(posedge mclk) disable iff (!rstn)
    pb.clr ##1 !pb.wr_en |=> pb.rd_data == calib_port_pkg::POT_CLEAR_VALUE)
    else $error("pot clear not seen on readback");

  // A commit to the selected slot shows on readback
  AST_BANK_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
    pb.wr_en && !pb.clr && pb.wr_addr == pb.rd_addr ##1 $stable(pb.rd_addr) && !pb.clr
    |=> pb.rd_data == $past(pb.wr_data, 2))
    else $error("pot setting not stored");

endmodule // pot_bank

// ---- design/calib_reset_port.sv ----
// Module: APB register port for serial EEPROM, calibration potentiometers and block resets
`timescale 1ns/100ps

module calib_reset_port #(
  parameter int ADDR_W         = 12,                                   // APB address width, at least 11
  parameter int EE_BUSY_CYCLES = calib_port_pkg::EE_BUSY_CYCLES        // EEPROM busy window in cycles
) (
  input  wire logic              mclk,                 // System clock, 100 MHz
  input  wire logic              rstn,                 // Synchronous reset, active low
  input  wire logic              psel,                 // APB select
  input  wire logic              penable,              // APB access phase
  input  wire logic              pwrite,               // APB direction, high for write
  input  wire logic [ADDR_W-1:0] paddr,                // APB byte address
  input  wire logic [31:0]       pwdata,               // APB write data
  output logic      [31:0]       prdata,               // APB read data
  output logic                   pready,               // APB ready
  output logic                   pslverr,              // APB error on unmapped address
  input  wire logic              ee_miso,              // EEPROM serial data from the part
  output logic                   ee_mosi,              // EEPROM serial data to the part
  output logic                   ee_sclk,              // EEPROM serial clock level
  output logic                   pot_mosi,             // Potentiometer serial data
  output logic                   pot_sclk,             // Potentiometer serial clock level
  output logic                   adc_buffer_clear,     // A/D buffer clear pulse
  output logic                   calib_pot_clear,      // Potentiometer clear pulse
  output logic                   parallel_port_clear,  // Digital port clear pulse
  output logic                   analog_out_clear,     // DAC clear pulse
  output logic                   global_clear          // Global clear pulse
);

  localparam int BUSY_W = $clog2(EE_BUSY_CYCLES + 1);

  pot_bank_if pb ();

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************

  logic miso_s1_reg;
  logic miso_s2_reg;

  // Two flops before anything reads the EEPROM data pin
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
    end
    else
    begin
      miso_s1_reg <= ee_miso;
      miso_s2_reg <= miso_s1_reg;
    end
  end

  // ****************************************************************
  // APB decode
  // ****************************************************************

  logic       pready_reg;
  logic       pready_next;
  logic       pslverr_reg;
  logic       pslverr_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [7:0] word_idx;
  logic       aligned;
  logic       hit_ee;
  logic       hit_pot;
  logic       hit_rst;
  logic       hit_sel;
  logic       hit_val;
  logic       hit_stat;
  logic       mapped;
  logic       access;
  logic       commit_wr;

  // Aligned word index; upper address bits must be zero
  assign word_idx = paddr[9:2];
  assign aligned  = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
  assign hit_ee   = aligned && (word_idx == calib_port_pkg::IDX_EE_PORT);
  assign hit_pot  = aligned && (word_idx == calib_port_pkg::IDX_POT_PORT);
  assign hit_rst  = aligned && (word_idx == calib_port_pkg::IDX_RESET);
  assign hit_sel  = aligned && (word_idx == calib_port_pkg::IDX_POT_SEL);
  assign hit_val  = aligned && (word_idx == calib_port_pkg::IDX_POT_VAL);
  assign hit_stat = aligned && (word_idx == calib_port_pkg::IDX_STATUS);
  assign mapped   = hit_ee || hit_pot || hit_rst || hit_sel || hit_val || hit_stat;

  // One wait state: ready rises in the second access cycle
  assign access    = psel && penable && !pready_reg;
  assign commit_wr = psel && penable && pready_reg && pwrite && !pslverr_reg;

  // ****************************************************************
  // Serial ports, pot frame decoder, busy timer
  // ****************************************************************

  logic                  ee_mosi_reg;
  logic                  ee_mosi_next;
  logic                  ee_sclk_reg;
  logic                  ee_sclk_next;
  logic                  pot_mosi_reg;
  logic                  pot_mosi_next;
  logic                  pot_sclk_reg;
  logic                  pot_sclk_next;
  calib_port_pkg::pot_state_type pot_state_reg;
  calib_port_pkg::pot_state_type pot_state_next;
  logic [9:0]            pot_shift_reg;
  logic [9:0]            pot_shift_next;
  logic [3:0]            pot_cnt_reg;
  logic [3:0]            pot_cnt_next;
  logic                  wr_en_reg;
  logic                  wr_en_next;
  logic [1:0]            wr_addr_reg;
  logic [1:0]            wr_addr_next;
  logic [7:0]            wr_data_reg;
  logic [7:0]            wr_data_next;
  logic [1:0]            pot_sel_reg;
  logic [1:0]            pot_sel_next;
  logic [BUSY_W-1:0]     busy_cnt_reg;
  logic [BUSY_W-1:0]     busy_cnt_next;
  logic [4:0]            clr_reg;
  logic [4:0]            clr_next;
  logic                  wd7;
  logic                  wd0;

  assign wd7 = pwdata[calib_port_pkg::SER_DATA_BIT];
  assign wd0 = pwdata[calib_port_pkg::SER_STROBE_BIT];

  // Next state of serial ports, pot decoder, resets and configuration
  always_comb
  begin
    ee_mosi_next   = ee_mosi_reg;
    ee_sclk_next   = ee_sclk_reg;
    pot_mosi_next  = pot_mosi_reg;
    pot_sclk_next  = pot_sclk_reg;
    pot_state_next = pot_state_reg;
    pot_shift_next = pot_shift_reg;
    pot_cnt_next   = pot_cnt_reg;
    wr_en_next     = 1'b0;
    wr_addr_next   = wr_addr_reg;
    wr_data_next   = wr_data_reg;
    pot_sel_next   = pot_sel_reg;
    busy_cnt_next  = (busy_cnt_reg != '0) ? busy_cnt_reg - 1'b1 : busy_cnt_reg;
    clr_next       = 5'h00;
    if (commit_wr && hit_ee)
    begin
      ee_mosi_next = wd7;
      ee_sclk_next = wd0;
      // Data bit 7 and clock bit 0 both low end a transaction; the part then needs its quiet window
      if (!wd7 && !wd0)
        busy_cnt_next = BUSY_W'(EE_BUSY_CYCLES);
    end
    if (commit_wr && hit_pot)
    begin
      pot_mosi_next = wd7;
      pot_sclk_next = wd0;
      unique case (pot_state_reg)
        calib_port_pkg::POT_IDLE:
        begin
          if (!wd0 && wd7)
          begin
            pot_state_next = calib_port_pkg::POT_SHIFT;
            pot_cnt_next   = 4'h0;
          end
        end
        calib_port_pkg::POT_SHIFT:
        begin
          if (wd0)
          begin
            pot_shift_next = {pot_shift_reg[8:0], wd7};
            pot_cnt_next   = pot_cnt_reg + 4'h1;
            if (pot_cnt_reg + 4'h1 == calib_port_pkg::POT_FRAME_BITS)
              pot_state_next = calib_port_pkg::POT_FULL;
          end
          else if (wd7)
            pot_cnt_next = 4'h0;
          else
            pot_state_next = calib_port_pkg::POT_IDLE;                 // Short frame is dropped
        end
        calib_port_pkg::POT_FULL:
        begin
          // Any extra strobe makes the frame too long and it is dropped
          pot_state_next = calib_port_pkg::POT_IDLE;
          if (!wd0 && !wd7)
          begin
            wr_en_next   = 1'b1;
            wr_addr_next = pot_shift_reg[9:8];
            wr_data_next = pot_shift_reg[7:0];
          end
        end
      endcase
    end
    if (commit_wr && hit_sel)
      pot_sel_next = pwdata[1:0];
    if (commit_wr && hit_rst)
    begin
      clr_next = pwdata[4:0];
      if (pwdata[calib_port_pkg::RST_GLOBAL_BIT])
        clr_next = 5'h1F;
    end
    // Global clear also returns all configuration to its reset value
    if (clr_reg[calib_port_pkg::RST_GLOBAL_BIT])
    begin
      ee_mosi_next   = 1'b0;
      ee_sclk_next   = 1'b0;
      pot_mosi_next  = 1'b0;
      pot_sclk_next  = 1'b0;
      pot_state_next = calib_port_pkg::POT_IDLE;
      pot_cnt_next   = 4'h0;
      pot_sel_next   = calib_port_pkg::POT_SEL_RESET;
    end
  end

  // Read data and error for the current access
  always_comb
  begin
    pready_next  = access;
    pslverr_next = access && !mapped;
    prdata_next  = 32'h0000_0000;
    if (access && !pwrite)
    begin
      if (hit_ee)
        prdata_next[calib_port_pkg::SER_DATA_BIT] = miso_s2_reg;
      else if (hit_sel)
        prdata_next[1:0] = pot_sel_reg;
      else if (hit_val)
        prdata_next[7:0] = pb.rd_data;
      else if (hit_stat)
      begin
        prdata_next[calib_port_pkg::ST_EE_BUSY_BIT]  = (busy_cnt_reg != '0);
        prdata_next[calib_port_pkg::ST_POT_OPEN_BIT] = (pot_state_reg != calib_port_pkg::POT_IDLE);
        prdata_next[calib_port_pkg::ST_POT_FULL_BIT] = (pot_state_reg == calib_port_pkg::POT_FULL);
        prdata_next[calib_port_pkg::ST_POT_CNT_LSB +: 4] = pot_cnt_reg;
      end
    end
  end

  // Register all state
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
      prdata_reg    <= 32'h0000_0000;
      ee_mosi_reg   <= 1'b0;
      ee_sclk_reg   <= 1'b0;
      pot_mosi_reg  <= 1'b0;
      pot_sclk_reg  <= 1'b0;
      pot_state_reg <= calib_port_pkg::POT_IDLE;
      pot_shift_reg <= 10'h000;
      pot_cnt_reg   <= 4'h0;
      wr_en_reg     <= 1'b0;
      wr_addr_reg   <= 2'h0;
      wr_data_reg   <= 8'h00;
      pot_sel_reg   <= calib_port_pkg::POT_SEL_RESET;
      busy_cnt_reg  <= '0;
      clr_reg       <= 5'h00;
    end
    else
    begin
      pready_reg    <= pready_next;
      pslverr_reg   <= pslverr_next;
      prdata_reg    <= prdata_next;
      ee_mosi_reg   <= ee_mosi_next;
      ee_sclk_reg   <= ee_sclk_next;
      pot_mosi_reg  <= pot_mosi_next;
      pot_sclk_reg  <= pot_sclk_next;
      pot_state_reg <= pot_state_next;
      pot_shift_reg <= pot_shift_next;
      pot_cnt_reg   <= pot_cnt_next;
      wr_en_reg     <= wr_en_next;
      wr_addr_reg   <= wr_addr_next;
      wr_data_reg   <= wr_data_next;
      pot_sel_reg   <= pot_sel_next;
      busy_cnt_reg  <= busy_cnt_next;
      clr_reg       <= clr_next;
    end
  end

  // ****************************************************************
  // Outputs and potentiometer bank
  // ****************************************************************

  assign prdata              = prdata_reg;
  assign pready              = pready_reg;
  assign pslverr             = pslverr_reg;
  assign ee_mosi             = ee_mosi_reg;
  assign ee_sclk             = ee_sclk_reg;
  assign pot_mosi            = pot_mosi_reg;
  assign pot_sclk            = pot_sclk_reg;
  assign adc_buffer_clear    = clr_reg[calib_port_pkg::RST_ADC_BIT];
  assign calib_pot_clear     = clr_reg[calib_port_pkg::RST_POT_BIT];
  assign parallel_port_clear = clr_reg[calib_port_pkg::RST_DIO_BIT];
  assign analog_out_clear    = clr_reg[calib_port_pkg::RST_DAC_BIT];
  assign global_clear        = clr_reg[calib_port_pkg::RST_GLOBAL_BIT];

  // Bank is cleared by the same pulse that leaves the block
  assign pb.wr_en   = wr_en_reg;
  assign pb.wr_addr = wr_addr_reg;
  assign pb.wr_data = wr_data_reg;
  assign pb.clr     = clr_reg[calib_port_pkg::RST_POT_BIT];
  assign pb.rd_addr = pot_sel_reg;

  pot_bank #(
    .DEPTH (4),
    .WIDTH (8)
  ) u_pot_bank (
    .mclk (mclk),
    .rstn (rstn),
    .pb   (pb)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************

  AST_EE_DRIVE: assert property (@(posedge mclk) disable iff (!rstn)
    commit_wr && hit_ee |=> ee_mosi == $past(pwdata[7]) && ee_sclk == $past(pwdata[0]))
    else $error("EEPROM port pins do not follow the write");

  AST_EE_READ: assert property (@(posedge mclk) disable iff (!rstn)
    access && !pwrite && hit_ee |=> pready && prdata[7] == $past(miso_s2_reg) && prdata[6:0] == 7'h00)
    else $error("EEPROM read bit not returned in bit 7");

  AST_POT_DRIVE: assert property (@(posedge mclk) disable iff (!rstn)
    commit_wr && hit_pot && !global_clear |=> pot_mosi == $past(pwdata[7]) && pot_sclk == $past(pwdata[0]))
    else $error("pot port pins do not follow the write");

  AST_POT_COMMIT: assert property (@(posedge mclk) disable iff (!rstn)
    commit_wr && hit_pot && pot_state_reg == calib_port_pkg::POT_FULL && pwdata[7:0] == 8'h00
    |=> pb.wr_en && {pb.wr_addr, pb.wr_data} == $past(pot_shift_reg))
    else $error("full pot frame not committed");

  AST_RST_ADC: assert property (@(posedge mclk) disable iff (!rstn)
    commit_wr && hit_rst |=> adc_buffer_clear == ($past(pwdata[0]) || $past(pwdata[4])))
    else $error("A/D buffer clear wrong");

  AST_RST_POT: assert property (@(posedge mclk) disable iff (!rstn)
    commit_wr && hit_rst && pwdata[1] |=> calib_pot_clear && pb.clr)
    else $error("pot clear missing");

  AST_RST_DIO_DAC: assert property (@(posedge mclk) disable iff (!rstn)
    commit_wr && hit_rst && pwdata[4:2] == 3'b011 |=> parallel_port_clear && analog_out_clear && !global_clear)
    else $error("port or DAC clear wrong");

  AST_RST_GLOBAL: assert property (@(posedge mclk) disable iff (!rstn)
    global_clear |-> adc_buffer_clear && calib_pot_clear && parallel_port_clear && analog_out_clear
    ##1 pot_sel_reg == calib_port_pkg::POT_SEL_RESET)
    else $error("global clear incomplete");

  AST_RST_PULSE: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(clr_reg != 5'h00) |=> clr_reg == 5'h00 [*2])
    else $error("clear pulse held too long");

endmodule // calib_reset_port

// ---- sim/ee_model.sv ----
// EEPROM partner model: offers one stored word bit by bit
`timescale 1ns/100ps
module ee_model #(
  parameter logic [15:0] WORD = 16'hA53C  // Stored word
) (
  input  wire logic       mclk,     // Bench clock
  input  wire logic       ee_mosi,  // Data from device
  input  wire logic       ee_sclk,  // Clock level from device
  input  wire logic [3:0] bit_idx,  // Bit on offer
  output logic            ee_miso   // Data to device
);
  logic open_reg = 1'b0;
  logic tog_reg  = 1'b0;
  // Enable code opens, end code closes a transaction
  always @(posedge mclk)
  begin
    tog_reg <= ~tog_reg;
    if (ee_mosi && !ee_sclk)
      open_reg <= 1'b1;
    else if (!ee_mosi && !ee_sclk)
      open_reg <= 1'b0;
  end
  // Released line toggles so a stale bit never passes
  assign ee_miso = open_reg ? WORD[bit_idx] : tog_reg;
endmodule // ee_model

// ---- sim/serial_calib_and_reset_port_test.sv ----
// Testbench: APB host driving serial ports and block resets
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module serial_calib_and_reset_port_test;
  localparam logic [15:0] WORD = 16'hA53C;
  localparam logic [7:0] EE_CMD [10] = '{8'h80, 8'h81, 8'h81, 8'h01, 8'h01, 8'h01, 8'h01, 8'h81, 8'h01, 8'h01};
  localparam logic [7:0] POT_VAL [4] = '{8'h00, 8'h4F, 8'hFF, 8'hA5};
  logic        mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, ee_miso, ee_mosi, ee_sclk, pot_mosi, pot_sclk;
  logic        adc_buffer_clear, calib_pot_clear, parallel_port_clear, analog_out_clear, global_clear;
  logic [3:0]  bit_idx = 4'h0;
  logic [4:0]  clr;
  int          n_mismatch = 0, tests_run = 0;
  // ****************
  // Clock, design and partner
  // ****************
  always #5 mclk = ~mclk;
  assign clr = {global_clear, analog_out_clear, parallel_port_clear, calib_pot_clear, adc_buffer_clear};
  calib_reset_port #(.EE_BUSY_CYCLES(50)) i_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ee_miso(ee_miso), .ee_mosi(ee_mosi), .ee_sclk(ee_sclk), .pot_mosi(pot_mosi), .pot_sclk(pot_sclk),
    .adc_buffer_clear(adc_buffer_clear), .calib_pot_clear(calib_pot_clear),
    .parallel_port_clear(parallel_port_clear), .analog_out_clear(analog_out_clear), .global_clear(global_clear));
  ee_model #(.WORD(WORD)) i_ee (.mclk(mclk), .ee_mosi(ee_mosi), .ee_sclk(ee_sclk), .bit_idx(bit_idx),
    .ee_miso(ee_miso));
  // ****************
  // Bus and check tasks
  // ****************
  task stop_test;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One APB transfer; bounded wait since pready timing is the design's
  task xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge mclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20)
    begin
      n_mismatch++;
      stop_test;
    end
  endtask
  // Spaced EEPROM write, pins checked once settled
  task ee_wr(input logic [7:0] d);
    repeat (400) @(posedge mclk);
    xfer(1'b1, 8'h18, {24'h0, d});
    @(posedge mclk);
    #1 `CHK({ee_mosi, ee_sclk}, {d[7], d[0]})
  endtask
  // Called in the time step of the completing edge: the pulse stands for the next cycle only
  task pulse_chk(input logic [4:0] e);
    #1 `CHK(clr, e)
    @(posedge mclk);
    #1 `CHK(clr, 5'h00)
  endtask
  // ****************
  // Scenarios
  // ****************
  task t_unmapped;
    xfer(1'b1, 8'h30, 32'hFF);
    `CHK(err, 1'b1)
    xfer(1'b0, 8'h30, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
  endtask
  task t_ee_read;
    for (int k = 0; k < 10; k++)
      ee_wr(EE_CMD[k]);
    for (int k = 0; k < 16; k++)
    begin
      bit_idx <= 4'(15 - k);
      repeat (400) @(posedge mclk);
      xfer(1'b0, 8'h18, 32'h0);
      `CHK(rd, {24'h0, WORD[15 - k], 7'h0})
    end
    ee_wr(8'h00);
    xfer(1'b0, 8'h22, 32'h0);
    `CHK(rd[0], 1'b1)
    repeat (60) @(posedge mclk);
    xfer(1'b0, 8'h22, 32'h0);
    `CHK(rd[0], 1'b0)
  endtask
  task t_pots;
    logic [9:0] f;
    for (int p = 0; p < 4; p++)
    begin
      f = {2'(p), POT_VAL[p]};
      xfer(1'b1, 8'h19, 32'h80);
      for (int b = 9; b >= 0; b--)
        xfer(1'b1, 8'h19, {24'h0, f[b], 7'h01});
      @(posedge mclk);
      #1 `CHK({pot_mosi, pot_sclk}, {f[0], 1'b1})
      xfer(1'b1, 8'h19, 32'h00);
    end
    // Read back all four so one slot cannot alias another
    for (int p = 0; p < 4; p++)
    begin
      xfer(1'b1, 8'h20, 32'(p));
      repeat (4) @(posedge mclk);
      xfer(1'b0, 8'h21, 32'h0);
      `CHK(rd[7:0], POT_VAL[p])
    end
    // A short frame must leave the selected setting alone
    xfer(1'b1, 8'h19, 32'h80);
    xfer(1'b1, 8'h19, 32'h81);
    xfer(1'b1, 8'h19, 32'h00);
    xfer(1'b0, 8'h21, 32'h0);
    `CHK(rd[7:0], POT_VAL[3])
  endtask
  task t_resets;
    xfer(1'b1, 8'h1B, 32'h00);
    pulse_chk(5'h00);
    for (int b = 0; b < 5; b++)
    begin
      xfer(1'b1, 8'h1B, 32'(1 << b));
      pulse_chk(b == 4 ? 5'h1F : 5'(1 << b));
    end
    // Port and DAC clears together, without the global one
    xfer(1'b1, 8'h1B, 32'h0C);
    pulse_chk(5'h0C);
    xfer(1'b0, 8'h20, 32'h0);
    `CHK(rd[1:0], 2'h0)
    xfer(1'b0, 8'h21, 32'h0);
    `CHK(rd[7:0], 8'h80)
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    t_unmapped;
    t_ee_read;
    t_pots;
    t_resets;
    stop_test;
  end
endmodule // serial_calib_and_reset_port_test
